// *** core/obpv_ctrl.v ***
// Programmer for a 128K x 8 one-time-programmable memory: program, verify, read ID.
// Assumes source bytes arrive one cycle after src_addr and external supply switches.
`timescale 1ns/1ps
`default_nettype none
`include "obpv_map.vh"
module obpv_ctrl (
    input  wire        mclk,              // System clock, 50 MHz.
    input  wire        rst,               // Synchronous reset, active high.
    input  wire        start_prog,        // Pulse: start a programming run.
    input  wire        start_id,          // Pulse: read both ID bytes.
    output reg  [16:0] src_addr,          // Address of wanted source byte.
    input  wire [7:0]  src_data,          // Source byte, valid a cycle later.
    output reg  [16:0] mem_addr,          // Memory address pins.
    output reg  [7:0]  data_out,          // Data to memory pins.
    output reg         data_oe_n,         // Low while we drive data.
    input  wire [7:0]  byte_outputs,      // Data from memory pins.
    output reg         chip_en_n,         // Chip enable, active low.
    output reg         out_en_n,          // Output enable, active low.
    output reg         program_strobe_n,  // Program strobe, active low.
    output reg         id_mode_address_pin, // Request high ID voltage.
    output reg         vcc_prog,          // Core supply to 6.5V, else 5.0V.
    output reg         vpp_prog,          // Program supply to 13.0V, else 5.0V.
    output reg         busy,              // Run in progress.
    output reg         done_pass,         // Pulse: device passed.
    output reg         done_fail,         // Pulse: device failed.
    output reg  [7:0]  maker_code,        // Maker ID byte read.
    output reg  [7:0]  type_code          // Device type ID byte read.
);
// ****************************************************************
// States
// ****************************************************************
    localparam S_IDLE = 12'h001, S_VCC = 12'h002, S_VPP = 12'h004, S_SET = 12'h008;
    localparam S_PULSE = 12'h010, S_HOLD = 12'h020, S_RD = 12'h040, S_CMP = 12'h080;
    localparam S_VPPOFF = 12'h100, S_VCCOFF = 12'h200, S_IDRD = 12'h400, S_END = 12'h800;
    reg [11:0] state_r;
    reg [1:0]  pass_r;            // 0 program, 1 verify loop, 2 final compare.
    reg [3:0]  retry_r;
    reg        fail_r;
    reg        id_sel_r;
    reg [7:0]  want_r;
    reg [7:0]  rd_s1_r, rd_s2_r;
    reg        tmr_load;
    reg [15:0] tmr_count;
    wire       tmr_done;
    function is_last;
        input [16:0] a;
        is_last = (a == `OBPV_ADDR_LAST);
    endfunction
    obpv_timer u_tmr (
        .mclk  (mclk),
        .rst   (rst),
        .load  (tmr_load),
        .count (tmr_count),
        .done  (tmr_done)
    );
    // Memory data crosses no clock but is asynchronous to us, so it is synchronised.
    always @(posedge mclk) begin
        rd_s1_r <= byte_outputs;
        rd_s2_r <= rd_s1_r;
    end
// ****************************************************************
// Sequencer
// ****************************************************************
    always @(posedge mclk) begin
        if (rst) begin
            state_r <= S_IDLE; pass_r <= 2'd0; retry_r <= 4'h0; fail_r <= 1'b0;
            id_sel_r <= 1'b0; want_r <= 8'h00; tmr_load <= 1'b0; tmr_count <= 16'h0000;
            src_addr <= `OBPV_ADDR_FIRST; mem_addr <= `OBPV_ADDR_FIRST;
            data_out <= 8'h00; data_oe_n <= 1'b1; chip_en_n <= 1'b1; out_en_n <= 1'b1;
            program_strobe_n <= 1'b1; id_mode_address_pin <= 1'b0;
            vcc_prog <= 1'b0; vpp_prog <= 1'b0; busy <= 1'b0;
            done_pass <= 1'b0; done_fail <= 1'b0; maker_code <= 8'h00; type_code <= 8'h00;
        end else begin
            tmr_load <= 1'b0;
            done_pass <= 1'b0;
            done_fail <= 1'b0;
            case (state_r)
            S_IDLE: begin
                if (start_prog) begin
                    busy <= 1'b1; pass_r <= 2'd0; fail_r <= 1'b0;
                    mem_addr <= `OBPV_ADDR_FIRST;
                    src_addr <= `OBPV_ADDR_FIRST;
                    vcc_prog <= 1'b1;
                    tmr_count <= `OBPV_SETUP_CYC; tmr_load <= 1'b1;
                    state_r <= S_VCC;
                end else if (start_id) begin
                    busy <= 1'b1; id_sel_r <= 1'b0;
                    mem_addr <= `OBPV_ID_ADDR_MAKER;
                    id_mode_address_pin <= 1'b1;
                    chip_en_n <= 1'b0; out_en_n <= 1'b0;
                    tmr_count <= `OBPV_SETUP_CYC; tmr_load <= 1'b1;
                    state_r <= S_IDRD;
                end
            end
            S_VCC: if (tmr_done) begin
                vpp_prog <= 1'b1;
                tmr_count <= `OBPV_SETUP_CYC; tmr_load <= 1'b1;
                state_r <= S_VPP;
            end
            S_VPP: if (tmr_done) begin
                want_r <= src_data; chip_en_n <= 1'b0;
                tmr_count <= `OBPV_SETUP_CYC; tmr_load <= 1'b1;
                state_r <= S_SET;
            end
            S_SET: begin
                data_out <= want_r; data_oe_n <= 1'b0; out_en_n <= 1'b1;
                if (tmr_done) begin
                    program_strobe_n <= 1'b0;
                    tmr_count <= `OBPV_PULSE_CYC; tmr_load <= 1'b1;
                    state_r <= S_PULSE;
                end
            end
            S_PULSE: if (tmr_done) begin
                program_strobe_n <= 1'b1;
                tmr_count <= `OBPV_SETUP_CYC; tmr_load <= 1'b1;
                state_r <= S_HOLD;
            end
            S_HOLD: if (tmr_done) begin
                data_oe_n <= 1'b1;
                if (pass_r == 2'd0) begin
                    if (is_last(mem_addr)) begin
                        pass_r <= 2'd1; retry_r <= 4'h0;
                        mem_addr <= `OBPV_ADDR_FIRST; src_addr <= `OBPV_ADDR_FIRST;
                        tmr_count <= `OBPV_SETUP_CYC; tmr_load <= 1'b1;
                        out_en_n <= 1'b0;
                        state_r <= S_RD;
                    end else begin
                        mem_addr <= mem_addr + 17'h00001;
                        src_addr <= mem_addr + 17'h00001;
                        tmr_count <= `OBPV_SETUP_CYC; tmr_load <= 1'b1;
                        state_r <= S_VPP;
                    end
                end else begin
                    retry_r <= retry_r + 4'h1;
                    out_en_n <= 1'b0;
                    tmr_count <= `OBPV_SETUP_CYC; tmr_load <= 1'b1;
                    state_r <= S_RD;
                end
            end
            S_RD: begin
                want_r <= src_data;
                program_strobe_n <= 1'b1; chip_en_n <= 1'b0; out_en_n <= 1'b0;
                if (tmr_done) state_r <= S_CMP;
            end
            S_CMP: begin
                if (rd_s2_r == want_r || pass_r == 2'd2) begin
                    if (rd_s2_r != want_r) fail_r <= 1'b1;
                    if (is_last(mem_addr)) begin
                        out_en_n <= 1'b1; chip_en_n <= 1'b1;
                        if (pass_r == 2'd1) begin
                            vpp_prog <= 1'b0;
                            tmr_count <= `OBPV_SETUP_CYC; tmr_load <= 1'b1;
                            state_r <= S_VPPOFF;
                        end else begin
                            state_r <= S_END;
                        end
                    end else begin
                        mem_addr <= mem_addr + 17'h00001;
                        src_addr <= mem_addr + 17'h00001;
                        retry_r <= 4'h0;
                        tmr_count <= `OBPV_SETUP_CYC; tmr_load <= 1'b1;
                        state_r <= S_RD;
                    end
                end else if (retry_r == `OBPV_RETRY_MAX) begin
                    fail_r <= 1'b1; out_en_n <= 1'b1; chip_en_n <= 1'b1;
                    vpp_prog <= 1'b0;
                    pass_r <= 2'd3;
                    tmr_count <= `OBPV_SETUP_CYC; tmr_load <= 1'b1;
                    state_r <= S_VPPOFF;
                end else begin
                    out_en_n <= 1'b1;
                    tmr_count <= `OBPV_SETUP_CYC; tmr_load <= 1'b1;
                    state_r <= S_SET;
                end
            end
            S_VPPOFF: if (tmr_done) begin
                vcc_prog <= 1'b0;
                tmr_count <= `OBPV_SETUP_CYC; tmr_load <= 1'b1;
                state_r <= S_VCCOFF;
            end
            S_VCCOFF: if (tmr_done) begin
                if (pass_r == 2'd3) begin
                    state_r <= S_END;
                end else begin
                    pass_r <= 2'd2;
                    mem_addr <= `OBPV_ADDR_FIRST; src_addr <= `OBPV_ADDR_FIRST;
                    chip_en_n <= 1'b0; out_en_n <= 1'b0;
                    tmr_count <= `OBPV_SETUP_CYC; tmr_load <= 1'b1;
                    state_r <= S_RD;
                end
            end
            S_IDRD: if (tmr_done) begin
                if (!id_sel_r) begin
                    maker_code <= rd_s2_r;
                    id_sel_r <= 1'b1;
                    mem_addr <= `OBPV_ID_ADDR_TYPE;
                    tmr_count <= `OBPV_SETUP_CYC; tmr_load <= 1'b1;
                end else begin
                    type_code <= rd_s2_r;
                    id_mode_address_pin <= 1'b0;
                    chip_en_n <= 1'b1; out_en_n <= 1'b1;
                    mem_addr <= `OBPV_ADDR_FIRST;
                    busy <= 1'b0;
                    state_r <= S_IDLE;
                end
            end
            S_END: begin
                busy <= 1'b0;
                done_pass <= ~fail_r;
                done_fail <= fail_r;
                state_r <= S_IDLE;
            end
            default: state_r <= S_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// *** core/obpv_map.vh ***
// Constants for the one-time-programmable memory programming controller.
// Assumes inclusion by bare name from the controller under core/ and from the pin checker.
`ifndef OBPV_MAP_VH
`define OBPV_MAP_VH
// ****************************************************************
// Geometry
// ****************************************************************
`define OBPV_ADDR_W        17
`define OBPV_DATA_W        8
`define OBPV_ADDR_FIRST    17'h00000
`define OBPV_ADDR_LAST     17'h1ffff
`define OBPV_ID_ADDR_MAKER 17'h00000
`define OBPV_ID_ADDR_TYPE  17'h00001
// ****************************************************************
// Timing, at a 50 MHz clock
// ****************************************************************
`define OBPV_CLK_MHZ       50
`define OBPV_PULSE_US      100
`define OBPV_PULSE_MIN_US  95
`define OBPV_PULSE_MAX_US  105
`define OBPV_SETUP_US      2
// The counts are the microsecond figures above times the clock rate.
// They are sized to the timer so that loading one never drops bits.
`define OBPV_PULSE_CYC     16'h1388
`define OBPV_SETUP_CYC     16'h0064
`define OBPV_TMR_W         16
// ****************************************************************
// Retry limit
// ****************************************************************
`define OBPV_RETRY_MAX     4'ha
`define OBPV_RETRY_W       4
`endif

// *** core/obpv_timer.v ***
// Down counter that raises done for one cycle, the loaded count of cycles after the load.
// Assumes a synchronous active-high reset on the same clock.
`timescale 1ns/1ps
`default_nettype none
module obpv_timer (
    input  wire        mclk,   // System clock.
    input  wire        rst,    // Synchronous reset.
    input  wire        load,   // Load pulse.
    input  wire [15:0] count,  // Cycles to wait.
    output reg         done    // Pulse when count elapses.
);
    reg [15:0] cnt_r;
    reg        run_r;
    always @(posedge mclk) begin
        if (rst) begin
            cnt_r <= 16'h0000;
            run_r <= 1'b0;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (load) begin
                cnt_r <= count;
                run_r <= 1'b1;
            end else if (run_r) begin
                if (cnt_r <= 16'h0001) begin
                    run_r <= 1'b0;
                    done  <= 1'b1;
                end else begin
                    cnt_r <= cnt_r - 16'h0001;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** verification/obpv_chk_properties.sv ***
// Concurrent checks on the pins of the memory programming controller.
// Assumes a bind from the bench top and a 50 MHz clock on mclk.
`timescale 1ns/1ps
`default_nettype none
`include "obpv_map.vh"
module obpv_chk (
    input wire logic        mclk,                // System clock.
    input wire logic        rst,                 // Synchronous reset.
    input wire logic        start_prog,          // Run request.
    input wire logic        busy,                // Run in progress.
    input wire logic [16:0] mem_addr,            // Address pins.
    input wire logic        data_oe_n,           // Data drive, active low.
    input wire logic        chip_en_n,           // Chip enable.
    input wire logic        out_en_n,            // Output enable.
    input wire logic        program_strobe_n,    // Program strobe.
    input wire logic        id_mode_address_pin, // ID voltage request.
    input wire logic        vcc_prog,            // Core supply raised.
    input wire logic        vpp_prog,            // Program supply raised.
    input wire logic        done_pass,           // Pass pulse.
    input wire logic        done_fail            // Fail pulse.
);
    localparam int LOW_MIN = `OBPV_PULSE_MIN_US * `OBPV_CLK_MHZ;
    localparam int LOW_MAX = `OBPV_PULSE_MAX_US * `OBPV_CLK_MHZ;
    logic [15:0] low_r;
    logic        first_r;
    // Counts sampled low cycles of the strobe; a rising strobe reads the full width.
    always_ff @(posedge mclk) begin
        if (rst) begin
            low_r <= 16'h0000;
            first_r <= 1'b0;
        end else begin
            low_r <= program_strobe_n ? 16'h0000 : low_r + 16'h0001;
            if (start_prog && !busy)
                first_r <= 1'b1;
            else if (!program_strobe_n)
                first_r <= 1'b0;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    chk_pulse_short: assert property ($rose(program_strobe_n) |-> low_r >= LOW_MIN)
        else $error("program pulse too short");
    chk_pulse_long: assert property (!program_strobe_n |-> low_r <= LOW_MAX)
        else $error("program pulse too long");
    chk_first_addr: assert property ($fell(program_strobe_n) && first_r |-> mem_addr == 17'h00000)
        else $error("first pulse not at first address");
    chk_supply_up: assert property (!program_strobe_n |-> vcc_prog && vpp_prog)
        else $error("pulse without raised supplies");
    chk_vcc_first: assert property ($rose(vpp_prog) |-> $past(vcc_prog, 50))
        else $error("program supply raised before core supply");
    chk_supply_pair: assert property (vpp_prog |-> vcc_prog)
        else $error("program supply up while core supply down");
    chk_write_drive: assert property (!program_strobe_n |-> !chip_en_n && !data_oe_n && out_en_n)
        else $error("pulse without chip enable and driven data");
    chk_read_quiet: assert property (!out_en_n |-> program_strobe_n && !chip_en_n && data_oe_n)
        else $error("read with strobe active or data driven");
    chk_id_lines: assert property (id_mode_address_pin && !out_en_n |-> mem_addr[16:1] == 16'h0000)
        else $error("upper address bits set in identification mode");
    chk_done_one: assert property (done_pass |-> !done_fail)
        else $error("pass and fail together");
endmodule
`default_nettype wire

// *** verification/obpv_mem_model.sv ***
// Behavioural one-time-programmable memory: array, programming and ID readout.
// Assumes the controller pins; no clock, reacts to pin levels and strobe edges.
`timescale 1ns/1ps
`default_nettype none
module obpv_mem_model #(
    parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary value.
    parameter logic [7:0] TYPE_CODE  = 8'hc3  // Arbitrary value.
) (
    input  wire logic [16:0] mem_addr,            // Address pins.
    input  wire logic [7:0]  data_out,            // Data from the controller.
    input  wire logic        data_oe_n,           // Controller drives data when low.
    input  wire logic        chip_en_n,           // Chip enable.
    input  wire logic        out_en_n,            // Output enable.
    input  wire logic        program_strobe_n,    // Program strobe.
    input  wire logic        id_mode_address_pin, // ID voltage applied.
    input  wire logic        vcc_prog,            // Core supply raised.
    input  wire logic        vpp_prog,            // Program supply raised.
    output wire logic [7:0]  byte_outputs         // Data to the controller.
);
    logic [7:0] cells [0:131071];
    logic [7:0] last_r;
    logic [7:0] rd_val;
    logic       drive;
    initial begin
        last_r = 8'h00;
        for (int i = 0; i < 131072; i++)
            cells[i] = 8'hff;
    end
    assign drive = !chip_en_n && !out_en_n && data_oe_n;
    assign rd_val = id_mode_address_pin ? (mem_addr[0] ? TYPE_CODE : MAKER_CODE)
                                        : cells[mem_addr];
    // A floating bus must not look like held data, so it shows the inverse of the last byte.
    always @* begin
        if (drive)
            last_r = rd_val;
    end
    assign byte_outputs = drive ? rd_val : ~last_r;
    // Programming only clears bits, as in a real cell.
    always @(negedge program_strobe_n) begin
        if (!chip_en_n && vcc_prog && vpp_prog)
            cells[mem_addr] = cells[mem_addr] & data_out;
    end
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench: reset state, ID readout, start of a program run, mid-run reset.
// Assumes obpv_ctrl and the memory model; a full run is far too long to simulate.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin err_total++; $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module tb;
    localparam logic [7:0] MAKER = 8'h5a; // Arbitrary value.
    localparam logic [7:0] TYPE  = 8'hc3; // Arbitrary value.
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        start_prog = 1'b0;
    logic        start_id = 1'b0;
    logic [7:0]  src_data = 8'h00;
    wire  [16:0] src_addr, mem_addr;
    wire  [7:0]  data_out, byte_outputs, maker_code, type_code;
    wire         data_oe_n, chip_en_n, out_en_n, program_strobe_n, id_mode_address_pin;
    wire         vcc_prog, vpp_prog, busy, done_pass, done_fail;
    int          err_total = 0;
    int          num_checks = 0;
    obpv_ctrl uut (.mclk(mclk), .rst(rst), .start_prog(start_prog), .start_id(start_id),
        .src_addr(src_addr), .src_data(src_data), .mem_addr(mem_addr), .data_out(data_out),
        .data_oe_n(data_oe_n), .byte_outputs(byte_outputs), .chip_en_n(chip_en_n),
        .out_en_n(out_en_n), .program_strobe_n(program_strobe_n),
        .id_mode_address_pin(id_mode_address_pin), .vcc_prog(vcc_prog), .vpp_prog(vpp_prog),
        .busy(busy), .done_pass(done_pass), .done_fail(done_fail), .maker_code(maker_code),
        .type_code(type_code));
    obpv_mem_model #(.MAKER_CODE(MAKER), .TYPE_CODE(TYPE)) u_mem (.mem_addr(mem_addr),
        .data_out(data_out), .data_oe_n(data_oe_n), .chip_en_n(chip_en_n),
        .out_en_n(out_en_n), .program_strobe_n(program_strobe_n),
        .id_mode_address_pin(id_mode_address_pin), .vcc_prog(vcc_prog),
        .vpp_prog(vpp_prog), .byte_outputs(byte_outputs));
    always #10 mclk = ~mclk;
    always @(posedge mclk) src_data <= src_addr[7:0] ^ 8'h3c;
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic pulse_start(input bit prog);
        @(posedge mclk);
        if (prog) start_prog <= 1'b1; else start_id <= 1'b1;
        @(posedge mclk);
        start_prog <= 1'b0;
        start_id <= 1'b0;
    endtask
    // Waits for the strobe to reach a level and notes any read seen meanwhile.
    task automatic wait_strobe(input logic lvl, output int n, output bit rd);
        n = 0;
        rd = 0;
        while (program_strobe_n !== lvl && n < 6000) begin
            @(posedge mclk); #1;
            n++;
            if (out_en_n === 1'b0) rd = 1;
        end
    endtask
    task t_idle;
        `CHK("idle pins", 6'b111000, {chip_en_n, out_en_n, program_strobe_n, vcc_prog, vpp_prog, busy})
        `CHK("idle outputs", 5'h10, {data_oe_n, busy, done_pass, done_fail, id_mode_address_pin})
        `CHK("idle address", 17'h00000, mem_addr)
    endtask
    task automatic t_id;
        int n;
        n = 0;
        pulse_start(0);
        @(posedge mclk); #1;
        while (busy !== 1'b0 && n < 2000) begin
            @(posedge mclk); #1;
            n++;
        end
        `CHK("maker code", MAKER, maker_code)
        `CHK("type code", TYPE, type_code)
        `CHK("id pin released", 1'b0, id_mode_address_pin)
    endtask
    task automatic t_prog;
        int n;
        bit rd;
        pulse_start(1);
        pulse_start(0);
        wait_strobe(1'b0, n, rd);
        `CHK("first address", 17'h00000, mem_addr)
        `CHK("supplies", 2'b11, {vcc_prog, vpp_prog})
        `CHK("refused id start", 1'b0, id_mode_address_pin)
        `CHK("first data", 8'h3c, data_out)
        `CHK("data driven", 2'b00, {data_oe_n, chip_en_n})
        wait_strobe(1'b1, n, rd);
        `CHK("pulse width", 1'b1, (n >= 4750 && n <= 5250))
        wait_strobe(1'b0, n, rd);
        `CHK("second address", 17'h00001, mem_addr)
        `CHK("second data", 8'h3d, data_out)
        `CHK("source address", 17'h00001, src_addr)
        `CHK("read in first pass", 1'b0, rd)
        `CHK("cell zero", 8'h3c, u_mem.cells[0])
        @(posedge mclk);
        rst <= 1'b1;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk); #1;
        t_idle();
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge mclk);
        err_total++;
        conclude();
    end
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk); #1;
        t_idle();
        t_id();
        t_prog();
        t_id();
        conclude();
    end
endmodule
bind obpv_ctrl obpv_chk u_chk (.mclk(mclk), .rst(rst), .start_prog(start_prog), .busy(busy),
    .mem_addr(mem_addr), .data_oe_n(data_oe_n), .chip_en_n(chip_en_n), .out_en_n(out_en_n),
    .program_strobe_n(program_strobe_n), .id_mode_address_pin(id_mode_address_pin),
    .vcc_prog(vcc_prog), .vpp_prog(vpp_prog), .done_pass(done_pass), .done_fail(done_fail));
`default_nettype wire
